// ===== rtl/pfac_pkg.sv
package pfac_pkg;
  // =====================================================================
  // flags word layout
  localparam int FLG_C = 0;
  localparam int FLG_Z = 1;
  localparam int FLG_I = 2;
  localparam int FLG_D = 3;
  localparam int FLG_B = 4;
  localparam int FLG_T = 5;
  localparam int FLG_V = 6;
  localparam int FLG_N = 7;
  // value after reset: mask flag set, others cleared (don't care to tests)
  localparam logic [7:0] FLAGS_RST = 8'h04;
  // =====================================================================
  // system clock divide in middle-speed mode
  localparam int MID_DIV = 4;
  // request register write becomes visible after this many instructions
  localparam int IRQ_LAG_INSTR = 1;
  // =====================================================================
  // operation codes of the core datapath
  typedef enum logic [3:0] {
    PFAC_OP_NOP   = 4'h0,
    PFAC_OP_ADC   = 4'h1,
    PFAC_OP_SUB_BORROW = 4'h2,
    PFAC_OP_SET_CARRY  = 4'h3,
    PFAC_OP_CLR_CARRY  = 4'h4,
    PFAC_OP_SED        = 4'h5,
    PFAC_OP_CLR_BCD    = 4'h6,
    PFAC_OP_MULTIPLY   = 4'h7,
    PFAC_OP_DIV   = 4'h8,
    PFAC_OP_WRPS  = 4'h9,
    PFAC_OP_AND   = 4'hA,
    PFAC_OP_INC   = 4'hB
  } pfac_op_e;
endpackage

// ===== rtl/pfac_clk_if.sv
`timescale 1ns/1ps
`default_nettype none
// system clock enable travelling from the divider to the core
interface pfac_clk_if;
  logic high_speed;
  logic sys_en;
  modport div (input high_speed, output sys_en);
  modport core (output high_speed, input sys_en);
endinterface
`default_nettype wire

// ===== rtl/pfac_clkdiv.sv
`timescale 1ns/1ps
`default_nettype none
module pfac_clkdiv (
  // clock and reset
  input  wire logic   clock_i,
  input  wire logic   sys_rst_i,
  // enable link
  pfac_clk_if.div     ck
);
  import pfac_pkg::*;
  logic [1:0] cnt_reg;
  // =====================================================================
  // divider: free count, enable on wrap or every cycle in high speed
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt_reg <= 2'h0;
    end else begin
      cnt_reg <= cnt_reg + 2'h1;
    end
  end
  assign ck.sys_en = ck.high_speed | (cnt_reg == 2'(MID_DIV - 1));
endmodule
`default_nettype wire

// ===== rtl/pfac_core.sv
// Behaviour
// - reset sets the interrupt-mask flag to one; other flags are undefined.
// - with BCD flag set, only add and subtract with carry are decimal adjusted.
// - negative, overflow and zero flags are meaningless in BCD mode.
// - multiply and divide ignore index-mode and BCD flags.
// - multiply and divide leave the whole flags word unchanged.
// - request register writes show in request bits one instruction later.
// - an instruction takes its cycle count times the system clock period.
// - after reset the system clock is oscillator divided by four; the core divides only while high_speed_i is low, reset does not force it.
`timescale 1ns/1ps
`default_nettype none
module pfac_core (
  // clock and reset
  input  wire logic              clock_i,
  input  wire logic              sys_rst_i,
  // instruction request
  input  wire logic              op_valid_i,
  input  wire pfac_pkg::pfac_op_e op_i,
  input  wire logic [7:0]        opa_i,
  input  wire logic [7:0]        opb_i,
  input  wire logic [3:0]        cycles_i,
  input  wire logic              high_speed_i,
  // request register access
  input  wire logic              irq_wr_i,
  input  wire logic [7:0]        irq_wdata_i,
  // results
  output logic                   op_ready_o,
  output logic                   op_done_o,
  output logic [7:0]             res_lo_o,
  output logic [7:0]             res_hi_o,
  output logic [7:0]             processor_flags_word_o,
  output logic [7:0]             irq_bits_o,
  output logic                   sys_en_o
);
  import pfac_pkg::*;

  typedef enum logic [0:0] {
    PFAC_IDLE = 1'b0,
    PFAC_EXEC = 1'b1
  } pfac_state_e;

  pfac_clk_if ck ();
  assign ck.high_speed = high_speed_i;

  pfac_clkdiv u_div (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .ck        (ck)
  );

  pfac_state_e state_reg;
  pfac_state_e state_next;
  pfac_op_e    op_reg;
  logic [7:0]  a_reg;
  logic [7:0]  b_reg;
  logic [3:0]  cyc_reg;
  logic [7:0]  flags_reg;
  logic [7:0]  flags_next;
  logic [7:0]  lo_reg;
  logic [7:0]  hi_reg;
  logic [7:0]  lo_next;
  logic [7:0]  hi_next;
  logic [7:0]  irq_reg;
  logic [7:0]  irq_pend_reg;
  logic        irq_pend_vld_reg;
  logic        done_reg;

  // =====================================================================
  // decimal and binary arithmetic
  wire        cin      = flags_reg[FLG_C];
  wire        dmode    = flags_reg[FLG_D];
  wire        is_sub   = (op_reg == PFAC_OP_SUB_BORROW);
  wire [7:0]  b_eff    = is_sub ? ~b_reg : b_reg;
  wire [8:0]  bin_sum  = {1'b0, a_reg} + {1'b0, b_eff} + {8'h00, cin};
  wire        bin_v    = (a_reg[7] == b_eff[7]) && (bin_sum[7] != a_reg[7]);
  // add: nibble adjust up by six; subtract: adjust down by six
  wire [4:0]  add_lo   = {1'b0, a_reg[3:0]} + {1'b0, b_reg[3:0]} + {4'h0, cin};
  wire        add_lc   = (add_lo > 5'h09);
  wire [4:0]  add_lo_a = add_lc ? 5'(add_lo + 5'h06) : add_lo;
  wire [4:0]  add_hi   = {1'b0, a_reg[7:4]} + {1'b0, b_reg[7:4]} + {4'h0, add_lc};
  wire        add_hc   = (add_hi > 5'h09);
  wire [4:0]  add_hi_a = add_hc ? 5'(add_hi + 5'h06) : add_hi;
  wire [4:0]  sub_lo   = {1'b0, a_reg[3:0]} - {1'b0, b_reg[3:0]} - {4'h0, ~cin};
  wire        sub_lb   = sub_lo[4];
  wire [3:0]  sub_lo_a = sub_lb ? 4'(sub_lo - 5'h06) : sub_lo[3:0];
  wire [4:0]  sub_hi   = {1'b0, a_reg[7:4]} - {1'b0, b_reg[7:4]} - {4'h0, sub_lb};
  wire        sub_hb   = sub_hi[4];
  wire [3:0]  sub_hi_a = sub_hb ? 4'(sub_hi - 5'h06) : sub_hi[3:0];
  wire        dec_op   = dmode && (op_reg == PFAC_OP_ADC || is_sub);
  wire [7:0]  dec_res  = is_sub ? {sub_hi_a, sub_lo_a} : {add_hi_a[3:0], add_lo_a[3:0]};
  wire        dec_c    = is_sub ? ~sub_hb : add_hc;
  wire [7:0]  arith    = dec_op ? dec_res : bin_sum[7:0];
  wire        arith_c  = dec_op ? dec_c : bin_sum[8];
  // multiply and divide never look at the flags word
  wire [15:0] mul_res  = a_reg * b_reg;
  wire [7:0]  div_q    = (b_reg == 8'h00) ? 8'hFF : 8'(a_reg / b_reg);
  wire [7:0]  div_r    = (b_reg == 8'h00) ? a_reg : 8'(a_reg % b_reg);

  // =====================================================================
  // next flags and results per operation
  always_comb begin
    flags_next = flags_reg;
    lo_next    = lo_reg;
    hi_next    = hi_reg;
    case (op_reg)
      PFAC_OP_ADC, PFAC_OP_SUB_BORROW: begin
        lo_next           = arith;
        flags_next[FLG_C] = arith_c;
        // in decimal mode these carry binary leftovers and mean nothing
        flags_next[FLG_Z] = (bin_sum[7:0] == 8'h00);
        flags_next[FLG_N] = bin_sum[7];
        flags_next[FLG_V] = bin_v;
      end
      PFAC_OP_AND: begin
        lo_next           = a_reg & b_reg;
        flags_next[FLG_Z] = ((a_reg & b_reg) == 8'h00);
        flags_next[FLG_N] = a_reg[7] & b_reg[7];
      end
      PFAC_OP_INC: begin
        lo_next           = 8'(a_reg + 8'h01);
        flags_next[FLG_Z] = (lo_next == 8'h00);
        flags_next[FLG_N] = lo_next[7];
      end
      PFAC_OP_SET_CARRY: flags_next[FLG_C] = 1'b1;
      PFAC_OP_CLR_CARRY: flags_next[FLG_C] = 1'b0;
      PFAC_OP_SED:       flags_next[FLG_D] = 1'b1;
      PFAC_OP_CLR_BCD:   flags_next[FLG_D] = 1'b0;
      PFAC_OP_WRPS:      flags_next = a_reg;
      PFAC_OP_MULTIPLY: begin
        lo_next = mul_res[7:0];
        hi_next = mul_res[15:8];
      end
      PFAC_OP_DIV: begin
        lo_next = div_q;
        hi_next = div_r;
      end
      default: begin
      end
    endcase
  end

  // =====================================================================
  // sequencer: instruction held for cycles_i system clock enables, one enable when cycles_i is zero
  wire last_cyc = ck.sys_en && (cyc_reg <= 4'h1);
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      PFAC_IDLE: if (op_valid_i) state_next = PFAC_EXEC;
      PFAC_EXEC: if (last_cyc) state_next = PFAC_IDLE;
      default:   state_next = PFAC_IDLE;
    endcase
  end
  assign op_ready_o = (state_reg == PFAC_IDLE);
  wire retire = (state_reg == PFAC_EXEC) && last_cyc;

  // state and operands
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_reg <= PFAC_IDLE;
      op_reg    <= PFAC_OP_NOP;
      a_reg     <= 8'h00;
      b_reg     <= 8'h00;
      cyc_reg   <= 4'h0;
    end else begin
      state_reg <= state_next;
      if (op_ready_o && op_valid_i) begin
        op_reg  <= op_i;
        a_reg   <= opa_i;
        b_reg   <= opb_i;
        cyc_reg <= cycles_i;
      end else if (state_reg == PFAC_EXEC && ck.sys_en) begin
        cyc_reg <= cyc_reg - 4'h1;
      end
    end
  end

  // flags and results, committed on the last cycle
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      flags_reg <= FLAGS_RST;
      lo_reg    <= 8'h00;
      hi_reg    <= 8'h00;
      done_reg  <= 1'b0;
    end else begin
      done_reg <= retire;
      if (retire) begin
        flags_reg <= flags_next;
        lo_reg    <= lo_next;
        hi_reg    <= hi_next;
      end
    end
  end

  // request bits: a write is parked and lands when the next instruction retires
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      irq_reg          <= 8'h00;
      irq_pend_reg     <= 8'h00;
      irq_pend_vld_reg <= 1'b0;
    end else begin
      if (irq_wr_i) begin
        irq_pend_reg     <= irq_wdata_i;
        irq_pend_vld_reg <= 1'b1;
      end else if (retire && irq_pend_vld_reg) begin
        irq_reg          <= irq_pend_reg;
        irq_pend_vld_reg <= 1'b0;
      end
    end
  end

  assign res_lo_o               = lo_reg;
  assign res_hi_o               = hi_reg;
  assign processor_flags_word_o = flags_reg;
  assign irq_bits_o             = irq_reg;
  assign op_done_o              = done_reg;
  assign sys_en_o               = ck.sys_en;

  // =====================================================================
  // checks
  logic [2:0] gap_reg;
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      gap_reg <= 3'h0;
    end else if (ck.sys_en) begin
      gap_reg <= 3'h0;
    end else begin
      gap_reg <= gap_reg + 3'h1;
    end
  end

  AST_RST_MASK: assert property (@(posedge clock_i)
    $fell(sys_rst_i) |-> processor_flags_word_o[FLG_I])
    else $error("mask flag not set after reset");
  AST_MULDIV_FLAGS: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    retire && (op_reg == PFAC_OP_MULTIPLY || op_reg == PFAC_OP_DIV)
      |=> $stable(processor_flags_word_o))
    else $error("multiply or divide changed flags");
  // product is rebuilt from the operands so a broken multiplier path is caught
  AST_PRODUCT: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    retire && op_reg == PFAC_OP_MULTIPLY
      |=> {res_hi_o, res_lo_o} == 16'($past(a_reg)) * 16'($past(b_reg)))
    else $error("multiply result wrong");
  AST_BCD_ADD: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    retire && dmode && op_reg == PFAC_OP_ADC && a_reg == 8'h25 && b_reg == 8'h38 && !cin
      |=> res_lo_o == 8'h63)
    else $error("decimal add not adjusted");
  AST_INC_BIN: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    retire && op_reg == PFAC_OP_INC && a_reg == 8'h09 |=> res_lo_o == 8'h0A)
    else $error("increment was decimal adjusted");
  AST_IRQ_HOLD: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    irq_wr_i && irq_bits_o != irq_wdata_i |=> irq_bits_o != $past(irq_wdata_i))
    else $error("request bits changed at once");
  AST_MID_DIV: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    !high_speed_i [*4] ##0 ck.sys_en
      |-> !$past(ck.sys_en, 1) && !$past(ck.sys_en, 2) && !$past(ck.sys_en, 3))
    else $error("middle speed enable too frequent");
  AST_GAP: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    gap_reg <= 3'(MID_DIV - 1))
    else $error("system clock enable missing");
  AST_HIGH_SPEED: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    high_speed_i |-> ck.sys_en)
    else $error("high speed enable not every cycle");
  COV_MULTIPLY: cover property (@(posedge clock_i) retire && op_reg == PFAC_OP_MULTIPLY);
  COV_BCD_SUB: cover property (@(posedge clock_i) retire && dmode && is_sub);
  COV_IRQ: cover property (@(posedge clock_i) irq_wr_i ##[1:40] retire);
endmodule
`default_nettype wire

// ===== verif/processor_flags_alu_core_tb.sv
`timescale 1ns/1ps
`default_nettype none
module processor_flags_alu_core_tb;
  import pfac_pkg::*;
  // =====================================================================
  // stimulus and observation
  logic       clock_i;
  logic       sys_rst_i;
  logic       op_valid_i;
  logic       high_speed_i;
  logic       irq_wr_i;
  pfac_op_e   op_i;
  logic [7:0] opa_i;
  logic [7:0] opb_i;
  logic [7:0] irq_wdata_i;
  logic [3:0] cycles_i;
  logic       op_ready_o;
  logic       op_done_o;
  logic       sys_en_o;
  logic [7:0] res_lo_o;
  logic [7:0] res_hi_o;
  logic [7:0] processor_flags_word_o;
  logic [7:0] irq_bits_o;
  int         errors;
  int         checks_done;
  int         took;
  int         k;

  pfac_core dut (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .op_valid_i(op_valid_i), .op_i(op_i),
    .opa_i(opa_i), .opb_i(opb_i), .cycles_i(cycles_i), .high_speed_i(high_speed_i),
    .irq_wr_i(irq_wr_i), .irq_wdata_i(irq_wdata_i), .op_ready_o(op_ready_o),
    .op_done_o(op_done_o), .res_lo_o(res_lo_o), .res_hi_o(res_hi_o),
    .processor_flags_word_o(processor_flags_word_o), .irq_bits_o(irq_bits_o),
    .sys_en_o(sys_en_o)
  );

  // 100 MHz clock
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  // =====================================================================
  // shared tasks
  task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chkn(input string name, input int lo, input int hi, input int got);
    checks_done++;
    if (got < lo || got > hi) begin
      errors++;
      $display("ERROR %s expected %0d..%0d seen %0d", name, lo, hi, got);
    end
  endtask

  // entered just after an edge; holds the request until it is taken
  task automatic run(input pfac_op_e op, input logic [7:0] a, input logic [7:0] b,
                     input logic [3:0] c);
    int n;
    n = 0;
    op_i = op;
    opa_i = a;
    opb_i = b;
    cycles_i = c;
    op_valid_i = 1'b1;
    while (op_ready_o !== 1'b1 && n < 100) begin
      @(posedge clock_i);
      #1;
      n++;
    end
    @(posedge clock_i);
    #1 op_valid_i = 1'b0;
    chk8("ready while busy", 8'h00, {7'h00, op_ready_o});
    took = 0;
    while (op_done_o !== 1'b1 && took < 100) begin
      @(posedge clock_i);
      #1;
      took++;
    end
    // a stuck handshake counts as a mismatch
    if (n >= 100 || took >= 100) begin
      errors++;
      $display("ERROR instruction handshake expected done seen timeout");
    end
  endtask

  // counts enable pulses over sixteen clocks
  task automatic count_en;
    k = 0;
    repeat (16) begin
      if (sys_en_o === 1'b1) k++;
      @(posedge clock_i);
      #1;
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // =====================================================================
  // scenarios
  task automatic t_reset;
    chk8("mask flag", 8'h04, processor_flags_word_o & 8'h04);
    count_en();
    chkn("reset enable count", 4, 4, k);
    $display("test reset done");
  endtask

  // only the carry and mode bits are judged; N, V, Z are invalid in decimal mode
  task automatic t_bcd;
    run(PFAC_OP_WRPS, 8'h0C, 8'h00, 4'h1);
    run(PFAC_OP_ADC, 8'h25, 8'h38, 4'h2);
    chk8("bcd add", 8'h63, res_lo_o);
    chk8("bcd add carry", 8'h00, processor_flags_word_o & 8'h01);
    run(PFAC_OP_NOP, 8'h00, 8'h00, 4'h1);
    run(PFAC_OP_SET_CARRY, 8'h00, 8'h00, 4'h1);
    run(PFAC_OP_SUB_BORROW, 8'h42, 8'h15, 4'h2);
    chk8("bcd sub", 8'h27, res_lo_o);
    chk8("bcd sub carry", 8'h01, processor_flags_word_o & 8'h01);
    run(PFAC_OP_INC, 8'h09, 8'h00, 4'h2);
    chk8("bcd inc", 8'h0A, res_lo_o);
    run(PFAC_OP_CLR_CARRY, 8'h00, 8'h00, 4'h1);
    chk8("carry clear", 8'h00, processor_flags_word_o & 8'h01);
    run(PFAC_OP_CLR_BCD, 8'h00, 8'h00, 4'h1);
    chk8("mode clear", 8'h00, processor_flags_word_o & 8'h08);
    run(PFAC_OP_ADC, 8'h25, 8'h38, 4'h2);
    chk8("binary add", 8'h5D, res_lo_o);
    $display("test bcd done");
  endtask

  task automatic t_muldiv;
    logic [7:0] f[2];
    f = '{8'h04, 8'h2C};
    foreach (f[i]) begin
      run(PFAC_OP_WRPS, f[i], 8'h00, 4'h1);
      run(PFAC_OP_MULTIPLY, 8'h12, 8'h34, 4'h8);
      chk8("product hi", 8'h03, res_hi_o);
      chk8("product lo", 8'hA8, res_lo_o);
      chk8("product flags", f[i], processor_flags_word_o);
      run(PFAC_OP_DIV, 8'h64, 8'h07, 4'h8);
      chk8("div quotient", 8'h0E, res_lo_o);
      chk8("div remainder", 8'h02, res_hi_o);
      chk8("div flags", f[i], processor_flags_word_o);
    end
    $display("test muldiv done");
  endtask

  task automatic t_irq;
    irq_wdata_i = 8'hA5;
    irq_wr_i = 1'b1;
    @(posedge clock_i);
    #1 irq_wr_i = 1'b0;
    repeat (3) @(posedge clock_i);
    #1;
    chk8("request bits early", 8'h00, irq_bits_o);
    run(PFAC_OP_NOP, 8'h00, 8'h00, 4'h1);
    @(posedge clock_i);
    #1;
    chk8("request bits late", 8'hA5, irq_bits_o);
    $display("test irq done");
  endtask

  // a zero count runs as one cycle; time counts edges after the take edge
  task automatic t_timing;
    int c[4];
    int e;
    c = '{0, 1, 5, 15};
    high_speed_i = 1'b1;
    foreach (c[i]) begin
      e = (c[i] == 0) ? 1 : c[i];
      run(PFAC_OP_NOP, 8'h00, 8'h00, 4'(c[i]));
      chkn("high speed time", e, e, took);
    end
    count_en();
    chkn("high speed enables", 16, 16, k);
    high_speed_i = 1'b0;
    run(PFAC_OP_NOP, 8'h00, 8'h00, 4'h3);
    chkn("middle speed time", 9, 12, took);
    count_en();
    chkn("middle speed enables", 4, 4, k);
    $display("test timing done");
  endtask

  // reset again in mid-run after software has cleared the mask flag
  task automatic t_rerun;
    high_speed_i = 1'b0;
    run(PFAC_OP_WRPS, 8'h00, 8'h00, 4'h1);
    chk8("mask cleared", 8'h00, processor_flags_word_o & 8'h04);
    sys_rst_i = 1'b1;
    repeat (3) @(posedge clock_i);
    #1 sys_rst_i = 1'b0;
    chk8("mask after reset", 8'h04, processor_flags_word_o & 8'h04);
    count_en();
    chkn("enables after reset", 4, 4, k);
    $display("test rerun done");
  endtask

  // =====================================================================
  // main sequence
  initial begin
    errors = 0;
    checks_done = 0;
    sys_rst_i = 1'b1;
    op_valid_i = 1'b0;
    op_i = PFAC_OP_NOP;
    opa_i = 8'h00;
    opb_i = 8'h00;
    cycles_i = 4'h1;
    high_speed_i = 1'b0;
    irq_wr_i = 1'b0;
    irq_wdata_i = 8'h00;
    repeat (20) @(posedge clock_i);
    #1 sys_rst_i = 1'b0;
    t_reset();
    high_speed_i = 1'b1;
    t_bcd();
    t_muldiv();
    t_irq();
    t_timing();
    t_rerun();
    wrap_up();
  end

  // tests need well under a thousand cycles; this cuts a hang short
  initial begin
    #100000;
    errors++;
    wrap_up();
  end
endmodule
`default_nettype wire
